//--- verilog/fsw_top.sv
/*
 Status register and write-protect logic of a serial flash, with the serial
 command front end it needs. Assumes SPI mode 0: serial_in sampled on rising
 sclk, status data shifted out on falling sclk, all pins synchronised into
 ref_clk, so sclk must run well below ref_clk/4.
*/
// Function
// R01 - Busy flag at status bit 0 during status-write, program or erase cycle.
// R02 - While busy, ignore every command except status read.
// R03 - Clear busy flag when the self-timed cycle finishes.
// R04 - Write latch at bit 1, set by the latch-set command.
// R05 - Clear latch at reset and after clear, program, erase, status-write.
// R06 - Two host-writable protect-select bits at status bits 3 and 2.
// R07 - Protect-select bits start at zero, nothing guarded.
// R08 - Status-lock bit at bit 7, host-writable, starts at zero.
// R09 - Status-write accepted only while the write latch is set.
// R10 - Host sends status-write as command byte plus one data byte.
// R11 - Status-write keeps bits 6..4, 1, 0; bits 6..4 read zero.
// R12 - Status-write discarded unless chip select rises right after data byte.
// R13 - Rising chip select starts timed cycle; then clear busy and latch.
// R14 - Lock bit zero: status-write allowed whatever the protect pin.
// R15 - Lock bit one and protect pin high: status-write allowed.
// R16 - Lock bit one and protect pin low: locked, status-write rejected.
// R17 - Locked mode entered in either order of lock bit and pin.
// R18 - Locked mode left only when the protect pin goes high.
// R19 - Program and erase into guarded area never execute.
// R20 - Write-type commands rejected unless chip select rises on byte boundary.
// R21 - Status read code 05h works at any time, even while busy.
// R22 - Status byte repeats for as long as chip select stays low; code sends it seven times, then shifts out zeros.
// R23 - Protect-select to guarded range is a parameterised lookup.
`timescale 1ns/100ps
module fsw_top
  import fsw_pkg::*;
#(
  parameter int unsigned CYC_WRITE = FSW_CYC_WRITE,
  parameter int unsigned CYC_PROG = FSW_CYC_PROG,
  parameter int unsigned CYC_ERASE = FSW_CYC_ERASE
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic chip_sel_b,
  input wire logic sclk,
  input wire logic serial_in,
  input wire logic write_protect_b,
  output logic serial_out,
  output logic serial_out_en,
  output logic [7:0] flash_status,
  output logic hard_locked_mode,
  output logic array_write_go
);
  typedef enum logic [2:0] {
    FSW_IDLE = 3'b001,
    FSW_STAT_OUT = 3'b010,
    FSW_SKIP = 3'b100
  } fsw_state_t;

  logic [2:0] cs_sync, ck_sync, di_sync, wp_sync;
  logic ck_prev;
  fsw_state_t state;
  logic [7:0] shift_in;
  logic [7:0] cmd;
  logic [7:0] out_shift;
  logic [FSW_BITCNT_W-1:0] bit_cnt;
  logic [23:0] addr;
  logic busy_flag, write_latch, protect_sel_hi, protect_sel_lo, status_lock;
  logic [FSW_TIMER_W-1:0] timer;

  wire logic cs_b = cs_sync[1];
  wire logic cs_prev_b = cs_sync[2];
  wire logic ck = ck_sync[1];
  wire logic di = di_sync[1];
  wire logic wp_n = wp_sync[1];
  wire logic cs_fall = cs_prev_b && !cs_b;
  wire logic cs_rise = !cs_prev_b && cs_b;
  wire logic ck_rise = ck && !ck_prev && !cs_b;
  wire logic ck_fall = !ck && ck_prev && !cs_b;
  wire logic [7:0] next_shift_in = {shift_in[6:0], di};
  wire logic byte_done = ck_rise && (bit_cnt[2:0] == 3'h7);
  wire logic on_boundary = (bit_cnt[2:0] == 3'h0);
  wire logic [7:0] status_value = {status_lock, 3'h0, protect_sel_hi, protect_sel_lo, write_latch, busy_flag};
  wire logic soft_lock_mode = !(status_lock && !wp_n);
  wire logic is_erase_blk = (cmd == FSW_CMD_ERASE_4K) ||
                            (cmd == FSW_CMD_BLK_ERASE_A) || (cmd == FSW_CMD_BLK_ERASE_B);
  wire logic is_chip_erase = (cmd == FSW_CMD_CE_A) || (cmd == FSW_CMD_CE_B);
  wire logic guarded;
  wire logic cmd_byte_done = byte_done && (bit_cnt == FSW_BITS_CMD - FSW_BITCNT_W'(1));
  // Acting only on the synced cs rise means a frame cut mid-byte never half-executes
  wire logic end_ok = cs_rise && on_boundary && !busy_flag;
  wire logic do_stat_write = end_ok && (cmd == FSW_CMD_STAT_WRITE) && (bit_cnt == FSW_BITS_STAT_WRITE) &&
                             write_latch && soft_lock_mode; // R09 R10 R12 R14 R15 R16 R17 R18
  wire logic do_latch_set = end_ok && (cmd == FSW_CMD_LATCH_SET) && (bit_cnt == FSW_BITS_CMD); // R04
  wire logic do_latch_clr = end_ok && (cmd == FSW_CMD_LATCH_CLR) && (bit_cnt == FSW_BITS_CMD); // R05
  wire logic do_prog = end_ok && (cmd == FSW_CMD_PAGE_WRITE) && (bit_cnt > FSW_BITS_ADDR) &&
                       write_latch && !guarded; // R19
  wire logic do_erase = end_ok && write_latch && !guarded &&
                        ((is_erase_blk && bit_cnt == FSW_BITS_ADDR) || (is_chip_erase && bit_cnt == FSW_BITS_CMD));
  wire logic start_cycle = do_stat_write || do_prog || do_erase;
  wire logic [FSW_TIMER_W-1:0] next_timer_load = do_stat_write ? FSW_TIMER_W'(CYC_WRITE) :
                                                 do_prog ? FSW_TIMER_W'(CYC_PROG) : FSW_TIMER_W'(CYC_ERASE);
  wire logic cycle_end = busy_flag && (timer == FSW_TIMER_W'(1));

  fsw_guard i_fsw_guard (
    .protect_sel({protect_sel_hi, protect_sel_lo}),
    .addr(addr[FSW_ADDR_W-1:0]),
    .whole_array(is_chip_erase),
    .guarded(guarded)
  );

  // Pins are asynchronous to ref_clk; bit 2 of cs_sync is an edge-detect tap
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_sync <= 3'h7;
      ck_sync <= 3'h0;
      di_sync <= 3'h0;
      wp_sync <= 3'h7;
      ck_prev <= 1'b0;
    end else begin
      cs_sync <= {cs_sync[1:0], chip_sel_b};
      ck_sync <= {ck_sync[1:0], sclk};
      di_sync <= {di_sync[1:0], serial_in};
      wp_sync <= {wp_sync[1:0], write_protect_b};
      ck_prev <= ck;
    end
  end

  // Frame decoder: count bits, capture command and address
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= FSW_IDLE;
      bit_cnt <= '0;
      shift_in <= 8'h00;
      cmd <= 8'h00;
      addr <= 24'h000000;
    end else if (cs_b) begin
      state <= FSW_IDLE;
      bit_cnt <= '0;
    end else if (ck_rise) begin
      shift_in <= next_shift_in;
      if (bit_cnt != FSW_BITCNT_MAX) begin
        bit_cnt <= bit_cnt + FSW_BITCNT_W'(1);
      end
      if (cmd_byte_done) begin
        cmd <= next_shift_in;
      end
      if (byte_done && bit_cnt > FSW_BITS_CMD && bit_cnt < FSW_BITS_ADDR) begin
        addr <= {addr[15:0], next_shift_in};
      end
      case (state)
        FSW_IDLE: begin
          if (cmd_byte_done) begin
            // R21 R02
            state <= (next_shift_in == FSW_CMD_STAT_READ) ? FSW_STAT_OUT : FSW_SKIP;
          end
        end
        FSW_STAT_OUT: state <= FSW_STAT_OUT;
        FSW_SKIP: state <= FSW_SKIP;
        default: state <= FSW_IDLE;
      endcase
    end
  end

  // Status byte shifted out MSB first on falling sclk, reloaded at the first seven byte boundaries only (bit_cnt stops at 63)
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_shift <= 8'h00;
      serial_out <= 1'b0;
      serial_out_en <= 1'b0;
    end else if (cs_b) begin
      serial_out_en <= 1'b0;
      serial_out <= 1'b0;
    end else if (ck_fall && state == FSW_STAT_OUT) begin
      // R22 R21
      if (on_boundary) begin
        serial_out <= status_value[7];
        out_shift <= {status_value[6:0], 1'b0};
      end else begin
        serial_out <= out_shift[7];
        out_shift <= {out_shift[6:0], 1'b0};
      end
      serial_out_en <= 1'b1;
    end
  end

  // Status bits and self-timed cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_flag <= 1'b0;
      write_latch <= 1'b0; // R05
      protect_sel_hi <= FSW_PSEL_RESET[1]; // R07
      protect_sel_lo <= FSW_PSEL_RESET[0];
      status_lock <= FSW_LOCK_RESET; // R08
      timer <= '0;
      array_write_go <= 1'b0;
    end else begin
      array_write_go <= do_prog || do_erase;
      if (start_cycle) begin
        // R13 R01
        busy_flag <= 1'b1;
        timer <= next_timer_load;
        if (do_stat_write) begin
          // R06 R11
          status_lock <= shift_in[FSW_BIT_LOCK];
          protect_sel_hi <= shift_in[FSW_BIT_PSEL_HI];
          protect_sel_lo <= shift_in[FSW_BIT_PSEL_LO];
        end
      end else if (cycle_end) begin
        // R03 R13 R05
        busy_flag <= 1'b0;
        timer <= '0;
        write_latch <= 1'b0;
      end else if (busy_flag) begin
        timer <= timer - FSW_TIMER_W'(1);
      end
      if (do_latch_set) begin
        write_latch <= 1'b1; // R04
      end else if (do_latch_clr) begin
        write_latch <= 1'b0; // R05
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      flash_status <= 8'h00;
      hard_locked_mode <= 1'b0;
    end else begin
      flash_status <= status_value; // R11
      hard_locked_mode <= !soft_lock_mode; // R16 R17 R18
    end
  end

  a_write_locked: assert property ( // R16
    @(posedge ref_clk) disable iff (!rst_b)
    (status_lock && !wp_n) |-> !do_stat_write)
    else $error("status write taken in locked mode");

  a_write_latch: assert property ( // R09
    @(posedge ref_clk) disable iff (!rst_b)
    do_stat_write |-> write_latch && !busy_flag)
    else $error("status write without latch");

  a_write_data: assert property ( // R06
    @(posedge ref_clk) disable iff (!rst_b)
    do_stat_write |=> {status_lock, protect_sel_hi, protect_sel_lo} ==
    {$past(shift_in[FSW_BIT_LOCK]), $past(shift_in[FSW_BIT_PSEL_HI]), $past(shift_in[FSW_BIT_PSEL_LO])})
    else $error("status bits not taken from data byte");

  a_bits_hold: assert property ( // R11
    @(posedge ref_clk) disable iff (!rst_b)
    !do_stat_write |=> $stable({status_lock, protect_sel_hi, protect_sel_lo}))
    else $error("status bits changed without a status write");

  a_busy_start: assert property ( // R13
    @(posedge ref_clk) disable iff (!rst_b)
    start_cycle |=> busy_flag && timer == $past(next_timer_load))
    else $error("cycle did not start");

  a_busy_hold: assert property ( // R01
    @(posedge ref_clk) disable iff (!rst_b)
    (busy_flag && !cycle_end) |=> busy_flag)
    else $error("busy dropped before cycle end");

  a_busy_end: assert property ( // R03
    @(posedge ref_clk) disable iff (!rst_b)
    cycle_end |=> !busy_flag && !write_latch)
    else $error("busy or latch not cleared");

  a_zero_bits: assert property ( // R11
    @(posedge ref_clk) disable iff (!rst_b)
    flash_status[6:4] == 3'h0)
    else $error("reserved status bits not zero");

  a_busy_ignore: assert property ( // R02
    @(posedge ref_clk) disable iff (!rst_b)
    busy_flag |-> !do_latch_set && !do_latch_clr && !start_cycle)
    else $error("command taken while busy");

  a_read_state: assert property ( // R21
    @(posedge ref_clk) disable iff (!rst_b)
    (state == FSW_IDLE && cmd_byte_done && next_shift_in == FSW_CMD_STAT_READ) |=> state == FSW_STAT_OUT)
    else $error("status read not started");

  a_out_release: assert property ( // R22
    @(posedge ref_clk) disable iff (!rst_b)
    cs_b |=> !serial_out_en)
    else $error("status output enabled while deselected");

  a_boundary: assert property ( // R20
    @(posedge ref_clk) disable iff (!rst_b)
    (cs_rise && !on_boundary && !busy_flag) |=> $stable(write_latch) && $stable(status_lock) && !busy_flag)
    else $error("off-boundary command ran");

  a_guard_block: assert property ( // R19
    @(posedge ref_clk) disable iff (!rst_b)
    (end_ok && write_latch && guarded) |=> !array_write_go)
    else $error("guarded area written");

  a_lock_flag: assert property ( // R17
    @(posedge ref_clk) disable iff (!rst_b)
    (status_lock && !wp_n) |=> hard_locked_mode)
    else $error("locked mode not shown");

  a_lock_exit: assert property ( // R18
    @(posedge ref_clk) disable iff (!rst_b)
    wp_n |=> !hard_locked_mode)
    else $error("locked mode held with pin high");

  a_latch_set: assert property ( // R04
    @(posedge ref_clk) disable iff (!rst_b)
    do_latch_set |=> write_latch)
    else $error("latch not set");

  a_latch_clear: assert property ( // R05
    @(posedge ref_clk) disable iff (!rst_b)
    do_latch_clr |=> !write_latch)
    else $error("latch not cleared");
endmodule

//--- verilog/fsw_pkg.sv
/*
 Shared constants for the flash status and write-protect block: command codes,
 status bit positions, reset values and self-timed cycle lengths.
 Assumes a 20 MHz ref_clk.
*/
package fsw_pkg;
  localparam int unsigned FSW_CLK_HZ = 20000000;
  localparam logic [7:0] FSW_CMD_LATCH_SET = 8'h06;
  localparam logic [7:0] FSW_CMD_LATCH_CLR = 8'h04;
  localparam logic [7:0] FSW_CMD_STAT_READ = 8'h05;
  localparam logic [7:0] FSW_CMD_STAT_WRITE = 8'h01;
  localparam logic [7:0] FSW_CMD_PAGE_WRITE = 8'h02;
  localparam logic [7:0] FSW_CMD_ERASE_4K = 8'h20;
  localparam logic [7:0] FSW_CMD_BLK_ERASE_A = 8'hd8;
  localparam logic [7:0] FSW_CMD_BLK_ERASE_B = 8'h52;
  localparam logic [7:0] FSW_CMD_CE_A = 8'hc7;
  localparam logic [7:0] FSW_CMD_CE_B = 8'h60;
  localparam int FSW_BIT_BUSY = 0;
  localparam int FSW_BIT_LATCH = 1;
  localparam int FSW_BIT_PSEL_LO = 2;
  localparam int FSW_BIT_PSEL_HI = 3;
  localparam int FSW_BIT_LOCK = 7;
  localparam logic [1:0] FSW_PSEL_RESET = 2'h0;
  localparam logic FSW_LOCK_RESET = 1'b0;
  // Cycle lengths in microseconds; counts are parameters of the top
  localparam int unsigned FSW_T_WRITE_US = 5000;
  localparam int unsigned FSW_T_PROG_US = 2000;
  localparam int unsigned FSW_T_ERASE_US = 200000;
  localparam int unsigned FSW_CYC_WRITE = FSW_T_WRITE_US * (FSW_CLK_HZ / 1000000);
  localparam int unsigned FSW_CYC_PROG = FSW_T_PROG_US * (FSW_CLK_HZ / 1000000);
  localparam int unsigned FSW_CYC_ERASE = FSW_T_ERASE_US * (FSW_CLK_HZ / 1000000);
  localparam int FSW_TIMER_W = 24;
  localparam int FSW_ADDR_W = 17;
  localparam int FSW_BITCNT_W = 6;
  localparam logic [FSW_BITCNT_W-1:0] FSW_BITS_CMD = 6'h08;
  localparam logic [FSW_BITCNT_W-1:0] FSW_BITS_STAT_WRITE = 6'h10;
  localparam logic [FSW_BITCNT_W-1:0] FSW_BITS_ADDR = 6'h20;
  localparam logic [FSW_BITCNT_W-1:0] FSW_BITCNT_MAX = 6'h3f;
endpackage

//--- verilog/fsw_guard.sv
/*
 Guarded-range lookup: given protect-select value and a target address, says
 whether the address is guarded. Pure combinational; the range table is a
 parameter, each entry being the lowest guarded address (top-down guarding).
*/
`timescale 1ns/100ps
module fsw_guard
  import fsw_pkg::*;
#(
  parameter logic [FSW_ADDR_W-1:0] GUARD_BASE_1 = 17'h18000,
  parameter logic [FSW_ADDR_W-1:0] GUARD_BASE_2 = 17'h10000
) (
  input wire logic [1:0] protect_sel,
  input wire logic [FSW_ADDR_W-1:0] addr,
  input wire logic whole_array,
  output logic guarded
);
  wire logic [FSW_ADDR_W-1:0] base;
  // Value 3 guards everything, value 0 nothing
  assign base = (protect_sel == 2'h1) ? GUARD_BASE_1 :
                (protect_sel == 2'h2) ? GUARD_BASE_2 : '0;
  assign guarded = (protect_sel == 2'h3) || ((protect_sel != 2'h0) && (whole_array || addr >= base)); // R23
endmodule

//--- bench/fsw_host.sv
/*
 Behavioural SPI host (mode 0) that drives the flash block's serial pins.
 Assumes ref_clk at 20 MHz; each sclk phase lasts HALF ref_clk cycles.
*/
`timescale 1ns/100ps
module fsw_host (
  input wire logic ref_clk,
  input wire logic serial_out,
  output logic chip_sel_b,
  output logic sclk,
  output logic serial_in
);
  localparam int HALF = 6;
  logic [31:0] rx;
  initial begin
    chip_sel_b = 1'b1;
    sclk = 1'b0;
    serial_in = 1'b1;
    rx = 32'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Shifts the low nbits of data MSB first; any bit count, not just whole bytes; cs rises after last fall
  task automatic xfer(input logic [39:0] data, input int nbits);
    tick(1);
    chip_sel_b = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      tick(HALF);
      sclk = 1'b0;
      serial_in = data[i];
      tick(HALF);
      sclk = 1'b1;
      rx = {rx[30:0], serial_out};
    end
    tick(HALF);
    sclk = 1'b0;
    tick(HALF);
    chip_sel_b = 1'b1;
    // Released line shows the inverse so a stale value is never mistaken for data
    serial_in = ~serial_in;
    tick(8);
  endtask
endmodule

//--- bench/flash_status_write_protect_bench.sv
/*
 Self-checking bench for fsw_top: status reads, status writes, locking and
 array write acceptance, all through the SPI host model. Short cycle counts.
*/
`timescale 1ns/100ps
module flash_status_write_protect_bench;
  import fsw_pkg::*;
  logic ref_clk, rst_b, write_protect_b, chip_sel_b, sclk, serial_in;
  logic serial_out, serial_out_en, hard_locked_mode, array_write_go;
  logic [7:0] flash_status;
  int error_cnt = 0, checks_done = 0, cyc = 0, go_cnt = 0, en_cnt = 0;
  logic [7:0] ops [6] = '{FSW_CMD_PAGE_WRITE, FSW_CMD_ERASE_4K, FSW_CMD_BLK_ERASE_A, FSW_CMD_BLK_ERASE_B,
                          FSW_CMD_CE_A, FSW_CMD_CE_B};
  int nb [6] = '{40, 32, 32, 32, 8, 8};
  fsw_top #(.CYC_WRITE(2000), .CYC_PROG(300), .CYC_ERASE(400)) i_fsw_top (
    .ref_clk(ref_clk), .rst_b(rst_b), .chip_sel_b(chip_sel_b), .sclk(sclk),
    .serial_in(serial_in), .write_protect_b(write_protect_b), .serial_out(serial_out),
    .serial_out_en(serial_out_en), .flash_status(flash_status),
    .hard_locked_mode(hard_locked_mode), .array_write_go(array_write_go));
  fsw_host i_fsw_host (.ref_clk(ref_clk), .serial_out(serial_out), .chip_sel_b(chip_sel_b),
    .sclk(sclk), .serial_in(serial_in));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (array_write_go === 1'b1) go_cnt++;
    if (serial_out_en === 1'b1) en_cnt++;
    if (cyc == 90000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    i_fsw_host.xfer({32'h0, op}, 8);
  endtask
  task automatic stat_write(input logic [7:0] v);
    i_fsw_host.xfer({24'h0, FSW_CMD_STAT_WRITE, v}, 16);
  endtask
  task automatic stat_read2(output logic [15:0] v);
    i_fsw_host.xfer({16'h0, FSW_CMD_STAT_READ, 16'h0}, 24);
    v = i_fsw_host.rx[15:0];
  endtask
  // Bounded so a stuck busy flag shows up as a status mismatch, not a hang
  task automatic wait_idle();
    for (int n = 0; n < 5000 && flash_status[0] !== 1'b0; n++) begin
      @(posedge ref_clk);
      #1;
    end
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic set_wp(input logic v);
    @(posedge ref_clk);
    #1 write_protect_b = v;
    repeat (8) @(posedge ref_clk);
    #1;
  endtask
  logic [15:0] rd;
  initial begin
    rst_b = 1'b0;
    write_protect_b = 1'b1;
    repeat (8) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge ref_clk);
    check("status at reset", flash_status, 16'h00);
    stat_read2(rd);
    check("read idle", rd, 16'h0000);
    check("read enable seen", 16'(en_cnt > 0), 16'h1);
    check("read enable off", serial_out_en, 16'h0);
    stat_write(8'h84);
    check("write without latch", flash_status, 16'h00);
    cmd(FSW_CMD_LATCH_SET);
    check("latch set", flash_status, 16'h02);
    cmd(FSW_CMD_LATCH_CLR);
    check("latch clear", flash_status, 16'h00);
    cmd(FSW_CMD_LATCH_SET);
    i_fsw_host.xfer({16'h0, FSW_CMD_STAT_WRITE, 8'h84, 1'b0}, 17);
    check("long write", flash_status, 16'h02);
    i_fsw_host.xfer({25'h0, FSW_CMD_STAT_WRITE, 7'h42}, 15);
    check("short write", flash_status, 16'h02);
    stat_write(8'hf4);
    check("busy on write", flash_status, 16'h87);
    stat_read2(rd);
    check("read while busy", rd, 16'h8787);
    cmd(FSW_CMD_LATCH_CLR);
    check("ignored while busy", flash_status, 16'h87);
    wait_idle();
    check("write done", flash_status, 16'h84);
    check("soft lock", hard_locked_mode, 16'h0);
    set_wp(1'b0);
    check("lock then pin", hard_locked_mode, 16'h1);
    cmd(FSW_CMD_LATCH_SET);
    stat_write(8'h00);
    check("locked write", flash_status, 16'h86);
    set_wp(1'b1);
    check("unlock", hard_locked_mode, 16'h0);
    stat_write(8'h00);
    wait_idle();
    check("pin high write", flash_status, 16'h00);
    set_wp(1'b0);
    cmd(FSW_CMD_LATCH_SET);
    stat_write(8'h80);
    wait_idle();
    check("pin low unlocked", flash_status, 16'h80);
    check("pin then lock", hard_locked_mode, 16'h1);
    set_wp(1'b1);
    cmd(FSW_CMD_LATCH_SET);
    stat_write(8'h0c);
    wait_idle();
    check("all guarded", flash_status, 16'h0c);
    cmd(FSW_CMD_LATCH_SET);
    i_fsw_host.xfer({FSW_CMD_PAGE_WRITE, 32'h00200000}, 40);
    check("guarded program", go_cnt[15:0], 16'h0);
    check("guarded keeps latch", flash_status, 16'h0e);
    stat_write(8'h00);
    wait_idle();
    for (int k = 0; k < 6; k++) begin
      cmd(FSW_CMD_LATCH_SET);
      i_fsw_host.xfer({ops[k], 32'h00200000} >> (40 - nb[k]), nb[k]);
      check("array write accepted", go_cnt[15:0], 16'(k + 1));
      check("array busy", flash_status, 16'h03);
      wait_idle();
      check("array done", flash_status, 16'h00);
    end
    cmd(FSW_CMD_LATCH_SET);
    stat_write(8'h04);
    wait_idle();
    check("upper range select", flash_status, 16'h04);
    cmd(FSW_CMD_LATCH_SET);
    i_fsw_host.xfer({FSW_CMD_PAGE_WRITE, 32'h01800000}, 40);
    check("guarded range", go_cnt[15:0], 16'h6);
    i_fsw_host.xfer({FSW_CMD_PAGE_WRITE, 32'h00200000}, 40);
    check("unguarded range", go_cnt[15:0], 16'h7);
    wait_idle();
    check("range write done", flash_status, 16'h04);
    complete_run();
  end
endmodule
